// ### hdl/frac_div_core.sv
// one fractional divider: integer plus numerator over 2^24
`timescale 1ns/100ps
module frac_div_core
	import frac_div_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_enable,
	input wire logic [INT_W-1:0] i_int,
	input wire logic [NUM_W-1:0] i_num,
	output logic o_tick
);
	logic [NUM_W-1:0] acc_r;
	logic [INT_W:0] cnt_r;
	logic [NUM_W:0] sum;
	logic [INT_W:0] period;

	// period stretches by one when the accumulator wraps
	assign sum = {1'b0, acc_r} + {1'b0, i_num};
	assign period = {1'b0, i_int} + {7'h00, sum[NUM_W]};

	// RQ24 accumulate and stretch
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			acc_r <= '0;
			cnt_r <= '0;
			o_tick <= 1'b0;
		end else if (!i_enable) begin
			cnt_r <= '0;
			o_tick <= 1'b0;
		end else if (cnt_r == '0) begin
			acc_r <= sum[NUM_W-1:0];
			cnt_r <= period - 8'h01;
			o_tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r - 8'h01;
			o_tick <= 1'b0;
		end
	end
endmodule // frac_div_core

// ### hdl/frac_div_pkg.sv
// constants for the fractional divider and spread clock block
package frac_div_pkg;
	localparam int NUM_W = 24;
	localparam int INT_W = 7;
	localparam logic [6:0] INT_MIN = 7'h06;
	localparam logic [6:0] INT_MAX = 7'h18;
	localparam logic [23:0] NUM_MAX = 24'hFFFFFF;
	localparam logic [7:0] UNLOCK_KEY = 8'h5B;
	localparam logic [7:0] LOCK_KEY = 8'h00;
	localparam int STEP_W = 13;
	localparam int GAIN_W = 8;
	localparam int TRIM_W = 16;
	localparam logic [2:0] PRESET_CUSTOM = 3'h4;
	localparam logic [15:0] TRIM_RESET = 16'h0000;
	localparam logic [6:0] INT_RESET = 7'h0C;
	localparam logic [6:0] SM_DIV_RESET = 7'h02;
	localparam logic [GAIN_W-1:0] GAIN_RESET = 8'h80;
	localparam logic [STEP_W-1:0] PRESET0_STEPS = 13'h0C80;
	localparam logic [STEP_W-1:0] PRESET1_STEPS = 13'h0C80;
	localparam logic [STEP_W-1:0] PRESET2_STEPS = 13'h0C80;
	localparam logic [STEP_W-1:0] PRESET3_STEPS = 13'h0C80;
	localparam logic [NUM_W-1:0] PRESET0_SIZE = 24'h000010;
	localparam logic [NUM_W-1:0] PRESET1_SIZE = 24'h000028;
	localparam logic [NUM_W-1:0] PRESET2_SIZE = 24'h000030;
	localparam logic [NUM_W-1:0] PRESET3_SIZE = 24'h000050;
	// channel ratio codes: 2,4,6,8,10,20,40
	localparam logic [5:0] RATIO_2 = 6'h02;
	localparam logic [5:0] RATIO_40 = 6'h28;
	typedef enum logic [1:0] {SPR_IDLE = 2'b00, SPR_UP = 2'b01, SPR_DOWN = 2'b11} spread_e;
endpackage

// ### hdl/spread_clock_ctrl.sv
// frequency synthesis control: two dividers, spread, channels, state machine clock
// Notes on behaviour
// RQ1 - only the first divider is ever modulated
// RQ2 - second divider off when no channel uses it
// RQ3 - channel ratio never below two
// RQ4 - above 200 MHz use combiner, matched dividers
// RQ5 - other output: shared frequency or channel ratio
// RQ6 - integer part seven bits, six to 24
// RQ7 - numerator 24 bits over 2^24
// RQ8 - ratios 2,4,6,8,10,20,40 only
// RQ9 - signed 16-bit resonator trim readable
// RQ10 - combine enables per channel bits
// RQ11 - combine copies first divider into second
// RQ12 - software keeps spread off while combining
// RQ13 - key 0x5B unlocks gain codes, 0x00 locks
// RQ14 - channel zero selects first divider then
// RQ15 - state machine clock divide is field plus two
// RQ16 - software sets state clock 40-50 MHz
// RQ17 - spread modulates first divider outputs only
// RQ18 - type bit: down or center spread
// RQ19 - preset select: four presets or custom
// RQ20 - custom depth from step count and size
// RQ21 - software sequences spread under power-down
// RQ22 - power-down holds, changes latched there
// RQ23 - autoload choice applied leaving power-down
// RQ24 - numerator accumulates, overflow stretches period
// RQ25 - triangular step profile up then down
`timescale 1ns/100ps
module spread_clock_ctrl
	import frac_div_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_power_down_control,
	input wire logic i_page_autoload_disable,
	input wire logic [INT_W-1:0] i_page0_integer,
	input wire logic [NUM_W-1:0] i_page0_numerator,
	input wire logic [INT_W-1:0] i_first_divider_integer_part,
	input wire logic [NUM_W-1:0] i_first_divider_fraction_numerator,
	input wire logic [INT_W-1:0] i_second_divider_integer_part,
	input wire logic [NUM_W-1:0] i_second_divider_fraction_numerator,
	input wire logic i_chan0_divider_source_select,
	input wire logic i_chan1_divider_source_select,
	input wire logic [5:0] i_chan0_division_ratio,
	input wire logic [5:0] i_chan1_division_ratio,
	input wire logic i_chan0_edge_combine_enable,
	input wire logic i_chan1_edge_combine_enable,
	input wire logic [INT_W-1:0] i_state_machine_clock_divide,
	input wire logic i_spread_enable,
	input wire logic i_spread_type,
	input wire logic [2:0] i_spread_preset_select,
	input wire logic [STEP_W-1:0] i_spread_step_count,
	input wire logic [NUM_W-1:0] i_spread_step_increment,
	input wire logic [7:0] i_key_write_data,
	input wire logic i_key_write,
	input wire logic [GAIN_W-1:0] i_gain_write_data,
	input wire logic i_first_gain_cal_write,
	input wire logic i_second_gain_cal_write,
	input wire logic [TRIM_W-1:0] i_resonator_trim_in,
	output logic o_output_zero,
	output logic o_output_one,
	output logic o_state_machine_clock,
	output logic o_second_divider_active,
	output logic o_config_error,
	output logic o_protect_unlocked,
	output logic [GAIN_W-1:0] o_first_gain_cal_code,
	output logic [GAIN_W-1:0] o_second_gain_cal_code,
	output logic signed [TRIM_W-1:0] o_resonator_frequency_trim,
	output logic o_low_power
);
	// *********************************************
	// active configuration
	// *********************************************
	logic [INT_W-1:0] int0_r, int1_r, sm_div_r;
	logic [NUM_W-1:0] num0_r, num1_r, step_size_r;
	logic [STEP_W-1:0] steps_r;
	logic [5:0] ratio0_r, ratio1_r;
	logic sel0_r, sel1_r, comb0_r, comb1_r, spr_en_r, spr_type_r;
	logic pd_d_r;
	logic combine;
	logic tick0, tick1, div1_en;

	// legal channel ratio check, used for both channels
	function automatic logic ratio_ok(input logic [5:0] r);
		ratio_ok = (r == 6'h02) || (r == 6'h04) || (r == 6'h06) || (r == 6'h08) ||
			(r == 6'h0A) || (r == 6'h14) || (r == 6'h28);
	endfunction

	function automatic logic int_ok(input logic [INT_W-1:0] v);
		int_ok = (v >= INT_MIN) && (v <= INT_MAX);
	endfunction

	assign combine = comb0_r | comb1_r;
	assign o_low_power = i_power_down_control;

	// RQ22 changes only taken while powered down; the live clocks never see a half write
	// RQ23 page reload on leaving low power unless disabled
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pd_d_r <= 1'b0;
			int0_r <= INT_RESET;
			num0_r <= '0;
			int1_r <= INT_RESET;
			num1_r <= '0;
			ratio0_r <= RATIO_2;
			ratio1_r <= RATIO_2;
			sel0_r <= 1'b0;
			sel1_r <= 1'b0;
			comb0_r <= 1'b0;
			comb1_r <= 1'b0;
			sm_div_r <= SM_DIV_RESET;
			spr_en_r <= 1'b0;
			spr_type_r <= 1'b0;
			steps_r <= '0;
			step_size_r <= '0;
		end else begin
			pd_d_r <= i_power_down_control;
			if (i_power_down_control) begin
				// RQ6 illegal integer ratios are not taken
				if (int_ok(i_first_divider_integer_part)) begin
					int0_r <= i_first_divider_integer_part;
				end
				// RQ7 full 24-bit numerator
				num0_r <= i_first_divider_fraction_numerator;
				// RQ11 combining copies first divider values
				if (i_chan0_edge_combine_enable || i_chan1_edge_combine_enable) begin
					if (int_ok(i_first_divider_integer_part)) begin
						int1_r <= i_first_divider_integer_part;
					end
					num1_r <= i_first_divider_fraction_numerator;
				end else begin
					if (int_ok(i_second_divider_integer_part)) begin
						int1_r <= i_second_divider_integer_part;
					end
					num1_r <= i_second_divider_fraction_numerator;
				end
				// RQ3 RQ8 only listed ratios accepted
				if (ratio_ok(i_chan0_division_ratio)) begin
					ratio0_r <= i_chan0_division_ratio;
				end
				if (ratio_ok(i_chan1_division_ratio)) begin
					ratio1_r <= i_chan1_division_ratio;
				end
				sel0_r <= i_chan0_divider_source_select;
				sel1_r <= i_chan1_divider_source_select;
				// RQ10 per-channel combine enables
				comb0_r <= i_chan0_edge_combine_enable;
				comb1_r <= i_chan1_edge_combine_enable;
				sm_div_r <= i_state_machine_clock_divide;
				spr_en_r <= i_spread_enable;
				spr_type_r <= i_spread_type;
				// RQ19 preset or custom step settings
				case (i_spread_preset_select)
					3'h0: begin
						steps_r <= PRESET0_STEPS;
						step_size_r <= PRESET0_SIZE;
					end
					3'h1: begin
						steps_r <= PRESET1_STEPS;
						step_size_r <= PRESET1_SIZE;
					end
					3'h2: begin
						steps_r <= PRESET2_STEPS;
						step_size_r <= PRESET2_SIZE;
					end
					3'h3: begin
						steps_r <= PRESET3_STEPS;
						step_size_r <= PRESET3_SIZE;
					end
					default: begin
						// RQ20 custom count and increment
						steps_r <= i_spread_step_count;
						step_size_r <= i_spread_step_increment;
					end
				endcase
			end else if (pd_d_r && !i_page_autoload_disable) begin
				int0_r <= i_page0_integer;
				num0_r <= i_page0_numerator;
				int1_r <= i_page0_integer;
				num1_r <= i_page0_numerator;
			end
		end
	end

	// *********************************************
	// protected gain calibration space
	// *********************************************

	// RQ13 key byte unlocks and relocks gain codes
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_protect_unlocked <= 1'b0;
			o_first_gain_cal_code <= GAIN_RESET;
			o_second_gain_cal_code <= GAIN_RESET;
		end else begin
			if (i_key_write && i_key_write_data == UNLOCK_KEY) begin
				o_protect_unlocked <= 1'b1;
			end else if (i_key_write && i_key_write_data == LOCK_KEY) begin
				o_protect_unlocked <= 1'b0;
			end
			if (o_protect_unlocked && i_first_gain_cal_write) begin
				o_first_gain_cal_code <= i_gain_write_data;
			end
			if (o_protect_unlocked && i_second_gain_cal_write) begin
				o_second_gain_cal_code <= i_gain_write_data;
			end
		end
	end

	// RQ9 trim presented as signed readback
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_resonator_frequency_trim <= TRIM_RESET;
		end else begin
			o_resonator_frequency_trim <= i_resonator_trim_in;
		end
	end

	// *********************************************
	// spread modulator
	// *********************************************
	spread_e spr_state_r;
	logic [STEP_W-1:0] step_cnt_r;
	logic [NUM_W-1:0] offset_r;
	logic [NUM_W+1:0] mod_sum;
	logic [NUM_W+STEP_W-1:0] swing;
	logic [INT_W-1:0] mod_int;
	logic [NUM_W-1:0] mod_num;

	// RQ25 triangle: up for steps, then down; one step per divider tick
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			spr_state_r <= SPR_IDLE;
			step_cnt_r <= '0;
			offset_r <= '0;
		end else begin
			case (spr_state_r)
				SPR_IDLE: begin
					offset_r <= '0;
					step_cnt_r <= '0;
					if (spr_en_r && !combine && !i_power_down_control && steps_r != '0) begin
						spr_state_r <= SPR_UP;
					end
				end
				SPR_UP: begin
					if (!spr_en_r || combine) begin
						spr_state_r <= SPR_IDLE;
					end else if (tick0) begin
						offset_r <= offset_r + step_size_r;
						if (step_cnt_r == steps_r - 13'h0001) begin
							step_cnt_r <= '0;
							spr_state_r <= SPR_DOWN;
						end else begin
							step_cnt_r <= step_cnt_r + 13'h0001;
						end
					end
				end
				SPR_DOWN: begin
					if (!spr_en_r || combine) begin
						spr_state_r <= SPR_IDLE;
					end else if (tick0) begin
						offset_r <= offset_r - step_size_r;
						if (step_cnt_r == steps_r - 13'h0001) begin
							step_cnt_r <= '0;
							spr_state_r <= SPR_UP;
						end else begin
							step_cnt_r <= step_cnt_r + 13'h0001;
						end
					end
				end
				default: spr_state_r <= SPR_IDLE;
			endcase
		end
	end

	// RQ18 down-spread raises the ratio; center rides half the swing below
	always_comb begin
		swing = steps_r * step_size_r;
		mod_sum = {2'b00, num0_r} + {2'b00, offset_r};
		if (spr_type_r) begin
			mod_sum = mod_sum - {2'b00, swing[NUM_W:1]};
		end
		mod_num = mod_sum[NUM_W-1:0];
		// two top bits as signed carry: a borrow steps the integer down
		mod_int = int0_r + {{5{mod_sum[NUM_W+1]}}, mod_sum[NUM_W+1:NUM_W]};
	end

	// *********************************************
	// dividers and channels
	// *********************************************
	logic [INT_W-1:0] eff_int0;
	logic [NUM_W-1:0] eff_num0;

	// RQ1 RQ17 only first divider sees the modulation
	assign eff_int0 = (spr_state_r != SPR_IDLE) ? mod_int : int0_r;
	assign eff_num0 = (spr_state_r != SPR_IDLE) ? mod_num : num0_r;

	// RQ2 second divider runs only when selected or combining
	// RQ4 RQ14 combining needs both dividers
	assign div1_en = combine | sel1_r | sel0_r;
	assign o_second_divider_active = div1_en;

	frac_div_core u_div0 (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_enable(!i_power_down_control),
		.i_int(eff_int0),
		.i_num(eff_num0),
		.o_tick(tick0)
	);

	frac_div_core u_div1 (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_enable(div1_en && !i_power_down_control),
		.i_int(int1_r),
		.i_num(num1_r),
		.o_tick(tick1)
	);

	// RQ12 RQ14 flag configurations software must avoid
	assign o_config_error = combine && (spr_en_r || (comb1_r && !comb0_r && sel0_r));

	logic [5:0] chcnt_r [2];
	logic [1:0] chout_r;
	logic [1:0] src_tick;
	logic [1:0] comb_v;
	logic [5:0] ratio_v [2];
	assign src_tick[0] = sel0_r ? tick1 : tick0;
	assign src_tick[1] = sel1_r ? tick1 : tick0;
	assign comb_v = {comb1_r, comb0_r};
	assign ratio_v[0] = ratio0_r;
	assign ratio_v[1] = ratio1_r;

	// RQ5 RQ8 channel toggles every ratio/2 ticks; combine passes both edges
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_chan
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					chcnt_r[g] <= '0;
					chout_r[g] <= 1'b0;
				end else if (comb_v[g]) begin
					chcnt_r[g] <= '0;
					if (tick0 | tick1) begin
						chout_r[g] <= ~chout_r[g];
					end
				end else if (src_tick[g]) begin
					if (chcnt_r[g] >= {1'b0, ratio_v[g][5:1]} - 6'h01) begin
						chcnt_r[g] <= '0;
						chout_r[g] <= ~chout_r[g];
					end else begin
						chcnt_r[g] <= chcnt_r[g] + 6'h01;
					end
				end
			end
		end
	endgenerate
	assign o_output_zero = chout_r[0];
	assign o_output_one = chout_r[1];

	// *********************************************
	// state machine clock
	// *********************************************
	logic [INT_W:0] sm_cnt_r;
	logic [INT_W:0] sm_total;
	logic sm_tick;
	assign sm_tick = sel0_r ? tick1 : tick0;
	assign sm_total = {1'b0, sm_div_r} + 8'h02;

	// RQ15 divide chosen source by field plus two
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sm_cnt_r <= '0;
			o_state_machine_clock <= 1'b0;
		end else if (sm_tick) begin
			if (sm_cnt_r >= sm_total - 8'h01) begin
				sm_cnt_r <= '0;
				o_state_machine_clock <= 1'b1;
			end else begin
				sm_cnt_r <= sm_cnt_r + 8'h01;
				o_state_machine_clock <= (sm_cnt_r + 8'h01) < {1'b0, sm_total[INT_W:1]};
			end
		end
	end
endmodule // spread_clock_ctrl

// ### tb/spread_clock_monitor.sv
// port checker for the spread clock control block
`timescale 1ns/100ps
module spread_clock_monitor
	import frac_div_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_power_down_control,
	input wire logic [7:0] i_key_write_data,
	input wire logic i_key_write,
	input wire logic [GAIN_W-1:0] i_gain_write_data,
	input wire logic i_first_gain_cal_write,
	input wire logic i_second_gain_cal_write,
	input wire logic [TRIM_W-1:0] i_resonator_trim_in,
	input wire logic o_state_machine_clock,
	input wire logic o_second_divider_active,
	input wire logic o_protect_unlocked,
	input wire logic [GAIN_W-1:0] o_first_gain_cal_code,
	input wire logic [GAIN_W-1:0] o_second_gain_cal_code,
	input wire logic signed [TRIM_W-1:0] o_resonator_frequency_trim,
	input wire logic o_low_power
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// ************************************
	// assertions
	// ************************************
	low_power_follow_a: assert property (o_low_power == i_power_down_control)
		else $error("low power flag differs from control");
	trim_delay_a: assert property (!$past(i_rst) |-> o_resonator_frequency_trim == $past(i_resonator_trim_in))
		else $error("trim not one cycle behind input");
	unlock_key_a: assert property (i_key_write && i_key_write_data == UNLOCK_KEY |=> o_protect_unlocked)
		else $error("unlock key did not unlock");
	lock_key_a: assert property (i_key_write && i_key_write_data == LOCK_KEY |=> !o_protect_unlocked)
		else $error("lock key did not lock");
	unlock_hold_a: assert property (!i_key_write |=> $stable(o_protect_unlocked))
		else $error("protection changed without key write");
	locked_gain_a: assert property (!o_protect_unlocked && i_first_gain_cal_write |=> $stable(o_first_gain_cal_code))
		else $error("gain code written while locked");
	gain_write_a: assert property (o_protect_unlocked && i_second_gain_cal_write |=> o_second_gain_cal_code == $past(i_gain_write_data))
		else $error("unlocked gain write lost");
	gain_hold_a: assert property (!i_second_gain_cal_write |=> $stable(o_second_gain_cal_code))
		else $error("gain code changed without write");
	// a half period is at least one divider tick, six cycles
	sm_width_a: assert property ($rose(o_state_machine_clock) |-> (o_state_machine_clock || o_low_power)[*4])
		else $error("state clock high phase too short");
	sm_freeze_a: assert property (o_low_power && $past(o_low_power) |=> $stable(o_state_machine_clock))
		else $error("state clock moved in low power");
	unlock_c: cover property (i_key_write && i_key_write_data == UNLOCK_KEY);
	second_on_c: cover property ($rose(o_second_divider_active));
	sm_clk_c: cover property ($rose(o_state_machine_clock));
endmodule // spread_clock_monitor

bind spread_clock_ctrl spread_clock_monitor i_mon (.i_clk(i_clk), .i_rst(i_rst),
	.i_power_down_control(i_power_down_control), .i_key_write_data(i_key_write_data),
	.i_key_write(i_key_write), .i_gain_write_data(i_gain_write_data),
	.i_first_gain_cal_write(i_first_gain_cal_write), .i_second_gain_cal_write(i_second_gain_cal_write),
	.i_resonator_trim_in(i_resonator_trim_in), .o_state_machine_clock(o_state_machine_clock),
	.o_second_divider_active(o_second_divider_active), .o_protect_unlocked(o_protect_unlocked),
	.o_first_gain_cal_code(o_first_gain_cal_code), .o_second_gain_cal_code(o_second_gain_cal_code),
	.o_resonator_frequency_trim(o_resonator_frequency_trim), .o_low_power(o_low_power));

// ### tb/testbench.sv
// self-checking bench for the spread clock control block
`timescale 1ns/100ps
module testbench
	import frac_div_pkg::*;
;
	logic i_clk, i_rst, pd, ald, s0, s1, c0, c1, se, st, kw, gw1, gw2;
	logic [6:0] p0i, fi, si, smd;
	logic [23:0] p0n, fn, sn, sz;
	logic [5:0] r0, r1;
	logic [2:0] sp;
	logic [12:0] sc;
	logic [7:0] kd, gd, g1, g2;
	logic [15:0] trim;
	logic signed [15:0] trm;
	logic o0, o1, smc, act, unl, lp, cfg;
	int err_count, total_checks;
	int ratios[7] = '{2, 4, 6, 8, 10, 20, 40};

	spread_clock_ctrl i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_power_down_control(pd),
		.i_page_autoload_disable(ald), .i_page0_integer(p0i), .i_page0_numerator(p0n),
		.i_first_divider_integer_part(fi), .i_first_divider_fraction_numerator(fn),
		.i_second_divider_integer_part(si), .i_second_divider_fraction_numerator(sn),
		.i_chan0_divider_source_select(s0), .i_chan1_divider_source_select(s1),
		.i_chan0_division_ratio(r0), .i_chan1_division_ratio(r1),
		.i_chan0_edge_combine_enable(c0), .i_chan1_edge_combine_enable(c1),
		.i_state_machine_clock_divide(smd), .i_spread_enable(se), .i_spread_type(st),
		.i_spread_preset_select(sp), .i_spread_step_count(sc), .i_spread_step_increment(sz),
		.i_key_write_data(kd), .i_key_write(kw), .i_gain_write_data(gd),
		.i_first_gain_cal_write(gw1), .i_second_gain_cal_write(gw2),
		.i_resonator_trim_in(trim), .o_output_zero(o0), .o_output_one(o1),
		.o_state_machine_clock(smc), .o_second_divider_active(act), .o_config_error(cfg),
		.o_protect_unlocked(unl), .o_first_gain_cal_code(g1), .o_second_gain_cal_code(g2),
		.o_resonator_frequency_trim(trm), .o_low_power(lp));

	// ************************************
	// clock and helpers
	// ************************************
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// cycles across n periods, counted from one rising edge to the nth rising edge after it
	task automatic period(input int sel, input int n, input logic [31:0] exp);
		int k;
		int rises;
		logic prev, cur;
		logic [31:0] cyc;
		k = 0;
		rises = 0;
		cyc = 32'h0;
		prev = 1'b1;
		while (rises <= n) begin
			@(negedge i_clk);
			k++;
			cur = (sel == 0) ? o0 : ((sel == 1) ? o1 : smc);
			if (rises > 0) cyc++;
			if (cur && !prev) rises++;
			prev = cur;
			if (k > 4000) begin
				err_count++;
				test_done();
			end
		end
		check(cyc, exp);
	endtask

	// config is only taken while power-down is high
	task automatic apply;
		pd = 1'b1;
		repeat (3) @(negedge i_clk);
		pd = 1'b0;
		repeat (40) @(negedge i_clk);
	endtask

	task automatic key(input logic [7:0] v);
		kd = v;
		kw = 1'b1;
		@(negedge i_clk);
		kw = 1'b0;
	endtask

	task automatic gain(input logic w1, input logic w2, input logic [7:0] v);
		gd = v;
		gw1 = w1;
		gw2 = w2;
		@(negedge i_clk);
		gw1 = 1'b0;
		gw2 = 1'b0;
	endtask

	// ************************************
	// scenarios
	// ************************************
	task automatic t_regs;
		check(g1, 8'h80); // reset code
		check({16'h0000, trm}, 32'h0); // trim reset
		trim = 16'h8001;
		@(negedge i_clk);
		check({16'h0000, trm}, 32'h8001); // negative trim
		gain(1'b1, 1'b0, 8'h11);
		check(g1, 8'h80); // locked write
		key(UNLOCK_KEY);
		check(unl, 1'b1); // unlocked
		gain(1'b1, 1'b1, 8'hD2);
		check({g1, g2}, 16'hD2D2); // both codes written
		key(LOCK_KEY);
		check(unl, 1'b0); // relocked
		gain(1'b0, 1'b1, 8'h33);
		check(g2, 8'hD2); // ignored write
	endtask

	task automatic t_ratios;
		foreach (ratios[i]) begin
			r1 = 6'(ratios[i]);
			apply();
			period(1, 1, 32'(ratios[i] * 6)); // every ratio
		end
		period(0, 4, 32'd48); // divide by two
	endtask

	task automatic t_limits;
		fn = 24'h800000;
		apply();
		period(0, 4, 32'd52); // half fraction
		fi = 7'h19;
		r0 = 6'h03;
		apply();
		period(0, 4, 32'd52); // illegal values kept
		fi = 7'h18;
		fn = 24'h0;
		r0 = 6'h02;
		apply();
		period(0, 1, 32'd48); // largest integer
		fi = 7'h06;
		repeat (20) @(negedge i_clk);
		period(0, 1, 32'd48); // no change outside power-down
		apply();
		period(2, 1, 32'd24); // field plus two
		ald = 1'b0;
		p0i = 7'h08;
		apply();
		period(0, 1, 32'd16); // page zero loaded
		ald = 1'b1;
		apply();
	endtask

	task automatic t_second;
		check(act, 1'b0); // no user
		s1 = 1'b1;
		si = 7'h0A;
		r1 = 6'h02;
		apply();
		check(act, 1'b1); // chan1 user
		period(1, 1, 32'd20); // second divider
		c0 = 1'b1;
		apply();
		check(act, 1'b1); // combine needs both
		period(1, 1, 32'd12); // values copied
		check(cfg, 1'b0); // legal combine
		se = 1'b1;
		apply();
		check(cfg, 1'b1); // spread while combining
		c0 = 1'b0;
		sp = PRESET_CUSTOM;
		sc = 13'h0010;
		sz = 24'h004000;
		for (int t = 0; t < 2; t++) begin
			st = t[0];
			se = 1'b1;
			apply();
			period(1, 4, 32'd80); // unmodulated second
		end
		se = 1'b0;
		s1 = 1'b0;
		apply();
		check(act, 1'b0); // disabled again
	endtask

	initial begin
		{pd, s0, s1, c0, c1, se, st, kw, gw1, gw2} = '0;
		i_rst = 1'b1;
		ald = 1'b1;
		// chan0 on first divider, state divide legal
		{p0i, fi, si, smd} = {7'h0C, 7'h06, 7'h0C, 7'h02};
		{p0n, fn, sn, sz} = '0;
		{r0, r1, sp, sc} = {6'h02, 6'h02, 3'h0, 13'h0};
		{kd, gd, trim} = '0;
		err_count = 0;
		total_checks = 0;
		repeat (6) @(negedge i_clk);
		i_rst = 1'b0;
		@(negedge i_clk);
		t_regs();
		t_ratios();
		t_limits();
		t_second();
		test_done();
	end
endmodule // testbench
